/* File: design/etd_tx_fetch.sv */
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module etd_tx_fetch
  import etd_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Descriptor memory master
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // Buffer handoff to the MAC
  output etd_txd_type      tx_desc,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic        tx_done,
  // Interrupt
  output logic             irq
);

  function automatic logic [7:0] etd_ofs(input logic [31:0] a);
    return {a[7:2], 2'b00};
  endfunction : etd_ofs

  logic [31:0]   base_r;
  logic [31:0]   cur_r;
  logic [31:0]   hrdata_r;
  logic [3:0]    ctrl_r;
  logic [1:0]    stat_r;
  logic [1:0]    mask_r;
  logic [1:0]    stat_nxt;
  logic [1:0]    stat_clr;
  logic          hold_r;
  logic          wr_pend_r;
  logic          rd_pend_r;
  logic          hreadyout_r;
  logic          hresp_r;
  logic          irq_r;
  logic [7:0]    acc_ofs_r;
  logic [31:0]   words_r [0:3];
  logic [1:0]    widx_r;
  etd_state_type st_r;
  logic          mem_req_r;
  logic          mem_we_r;
  logic [31:0]   mem_addr_r;
  logic [31:0]   mem_wdata_r;
  etd_txd_type   txd_r;
  logic          tx_valid_r;

  // Bus decode
  wire         addr_ph = hsel & hready & htrans[1];
  wire         rd_ph   = addr_ph & ~hwrite;
  wire         wr_ph   = addr_ph & hwrite;
  wire [7:0]   ofs     = etd_ofs(haddr);
  wire         wr_ctrl = wr_pend_r & (acc_ofs_r == OFS_CTRL);
  wire         wr_base = wr_pend_r & (acc_ofs_r == OFS_BASE);
  wire         wr_stat = wr_pend_r & (acc_ofs_r == OFS_STAT);
  wire         wr_mask = wr_pend_r & (acc_ofs_r == OFS_MASK);
  wire [31:0]  stat_rd = {27'h000_0000, hold_r, 2'b00, stat_r};
  wire [31:0]  rd_mux  = (acc_ofs_r == OFS_CTRL) ? {28'h000_0000, ctrl_r} :
                         (acc_ofs_r == OFS_BASE) ? base_r :
                         (acc_ofs_r == OFS_CUR)  ? cur_r :
                         (acc_ofs_r == OFS_STAT) ? stat_rd :
                         (acc_ofs_r == OFS_MASK) ? {30'h0000_0000, mask_r} : RST_WORD;

  // Descriptor decode
  wire [31:0]  w1       = words_r[1];
  wire [13:0]  len      = w1[W1_LEN_HI:0];
  wire         last     = w1[W1_LS];
  wire         ip_ins   = ctrl_r[CTRL_IPG] | w1[W1_IP];
  wire         tcp_ins  = ctrl_r[CTRL_TCPG] | w1[W1_TCP];
  wire         udp_ins  = ctrl_r[CTRL_UDPG] | w1[W1_UDP];
  wire         fetch_ack = (st_r == S_FETCH) & mem_ack;
  wire         halt_ev  = fetch_ack & (widx_r == 2'd0) & ~mem_rdata[W0_OWN];
  wire         done_ev  = (st_r == S_WB) & mem_ack & w1[W1_IC] & last;
  wire [31:0]  next_ptr = w1[W1_WRAP] ? base_r : {words_r[LAST_WORD][31:2], 2'b00};

  // Sticky status, set wins over write-one-to-clear
  assign stat_clr = wr_stat ? hwdata[1:0] : 2'b00;
  assign stat_nxt = (stat_r & ~stat_clr) | {halt_ev, done_ev};

  assign hreadyout = hreadyout_r;
  assign hrdata    = hrdata_r;
  assign hresp     = hresp_r;
  assign mem_req   = mem_req_r;
  assign mem_we    = mem_we_r;
  assign mem_addr  = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign tx_desc   = txd_r;
  assign tx_valid  = tx_valid_r;
  assign irq       = irq_r;

  // Bus slave: writes land in the data phase, reads take one wait state
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_pend_r   <= 1'b0;
      rd_pend_r   <= 1'b0;
      acc_ofs_r   <= OFS_CTRL;
      hrdata_r    <= RST_WORD;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      wr_pend_r   <= wr_ph;
      rd_pend_r   <= rd_ph;
      hreadyout_r <= ~rd_ph;
      hresp_r     <= 1'b0;
      if (addr_ph) begin
        acc_ofs_r <= ofs;
      end
      hrdata_r <= rd_pend_r ? rd_mux : RST_WORD;
    end
  end

  // Software registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_r <= RST_CTRL;
      base_r <= RST_WORD;
      mask_r <= RST_STAT;
      stat_r <= RST_STAT;
      irq_r  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= hwdata[3:0];
      end
      if (wr_base) begin
        base_r <= {hwdata[31:2], 2'b00};
      end
      if (wr_mask) begin
        mask_r <= hwdata[1:0];
      end
      stat_r <= stat_nxt;
      irq_r  <= |(stat_nxt & mask_r);
    end
  end

  // Halt after a host-owned descriptor; a control write clears the hold, and the walk resumes only if it sets the run bit
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hold_r <= 1'b0;
    end else if (halt_ev) begin
      hold_r <= 1'b1;
    end else if (wr_ctrl) begin
      hold_r <= 1'b0;
    end
  end

  // Fetched descriptor words
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        words_r[i] <= RST_WORD;
      end
    end else if (fetch_ack) begin
      words_r[widx_r] <= mem_rdata;
    end
  end

  // Descriptor walk
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_r        <= S_IDLE;
      widx_r      <= 2'd0;
      cur_r       <= RST_WORD;
      mem_req_r   <= 1'b0;
      mem_we_r    <= 1'b0;
      mem_addr_r  <= RST_WORD;
      mem_wdata_r <= RST_WORD;
      txd_r       <= '0;
      tx_valid_r  <= 1'b0;
    end else begin
      unique case (st_r)
        S_IDLE: begin
          if (ctrl_r[CTRL_RUN] & ~hold_r) begin
            mem_req_r  <= 1'b1;
            mem_we_r   <= 1'b0;
            mem_addr_r <= cur_r;
            widx_r     <= 2'd0;
            st_r       <= S_FETCH;
          end else if (wr_base) begin
            cur_r <= {hwdata[31:2], 2'b00};
          end
        end
        S_FETCH: begin
          if (mem_ack) begin
            if (halt_ev) begin
              mem_req_r <= 1'b0;
              st_r      <= S_IDLE;
            end else if (widx_r == 2'(LAST_WORD)) begin
              mem_req_r <= 1'b0;
              st_r      <= S_ISSUE;
            end else begin
              widx_r     <= widx_r + 2'd1;
              mem_addr_r <= mem_addr_r + WORD_STEP;
            end
          end
        end
        S_ISSUE: begin
          if (len == 14'h0000) begin
            mem_req_r   <= 1'b1;
            mem_we_r    <= 1'b1;
            mem_addr_r  <= cur_r;
            mem_wdata_r <= DESC_W0_DONE;
            st_r        <= S_WB;
          end else begin
            txd_r.buf_addr <= words_r[2];
            txd_r.len      <= len;
            txd_r.first    <= w1[W1_FS];
            txd_r.last     <= last;
            txd_r.ins_ip   <= ip_ins;
            txd_r.ins_tcp  <= tcp_ins;
            txd_r.ins_udp  <= udp_ins;
            tx_valid_r     <= 1'b1;
            st_r           <= S_XFER;
          end
        end
        S_XFER: begin
          if (tx_ready) begin
            tx_valid_r <= 1'b0;
            st_r       <= S_DONE;
          end
        end
        S_DONE: begin
          if (tx_done) begin
            mem_req_r   <= 1'b1;
            mem_we_r    <= 1'b1;
            mem_addr_r  <= cur_r;
            mem_wdata_r <= DESC_W0_DONE;
            st_r        <= S_WB;
          end
        end
        S_WB: begin
          if (mem_ack) begin
            mem_req_r <= 1'b0;
            mem_we_r  <= 1'b0;
            st_r      <= S_NEXT;
          end
        end
        S_NEXT: begin
          cur_r <= next_ptr;
          st_r  <= S_IDLE;
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  chk_own_halt_stop: assert property (
    (st_r == S_FETCH && mem_ack && widx_r == 2'd0 && !mem_rdata[W0_OWN])
      |=> (st_r == S_IDLE && !mem_req_r && hold_r && !tx_valid_r)
  ) else $error("host-owned descriptor did not stop the walk");

  chk_wb_own_clear: assert property (
    (mem_req_r && mem_we_r) |-> (mem_wdata_r[W0_OWN] == 1'b0 && mem_addr_r == cur_r)
  ) else $error("write-back does not return ownership");

  chk_irq_last_seg: assert property (
    $rose(stat_r[ST_DONE]) |-> $past(st_r) == S_WB && $past(w1[W1_IC]) && $past(w1[W1_LS])
  ) else $error("completion flag without last segment and request");

  chk_first_seg_out: assert property (
    (st_r == S_ISSUE && len != 14'h0000)
      |=> tx_valid_r && txd_r.first == $past(w1[W1_FS]) && txd_r.last == $past(w1[W1_LS])
  ) else $error("segment markers not passed on");

  chk_ring_wrap: assert property (
    (st_r == S_NEXT && w1[W1_WRAP]) |=> cur_r == $past(base_r)
  ) else $error("end of ring did not return to base");

  chk_zero_skip: assert property (
    (st_r == S_ISSUE && len == 14'h0000) |=> (st_r == S_WB && !tx_valid_r)[*1] ##0 mem_we_r
  ) else $error("empty buffer was not skipped");

  chk_ip_global: assert property (
    $rose(tx_valid_r) |-> txd_r.ins_ip == ($past(ctrl_r[CTRL_IPG]) | $past(w1[W1_IP]))
  ) else $error("IP sum request wrong");

  chk_tcp_udp_sum: assert property (
    $rose(tx_valid_r) |-> txd_r.ins_tcp == ($past(ctrl_r[CTRL_TCPG]) | $past(w1[W1_TCP]))
                       && txd_r.ins_udp == ($past(ctrl_r[CTRL_UDPG]) | $past(w1[W1_UDP]))
  ) else $error("TCP or UDP sum request wrong");

  chk_word_fetch: assert property (
    (fetch_ack && widx_r != 2'(LAST_WORD) && !halt_ev)
      |=> mem_req_r && mem_addr_r == $past(mem_addr_r) + WORD_STEP
  ) else $error("descriptor words not fetched in sequence");

  chk_irq_level: assert property (
    ##1 irq_r == |($past(stat_nxt) & $past(mask_r))
  ) else $error("interrupt output does not follow masked status");

  chk_no_fetch_held: assert property (
    (hold_r && st_r == S_IDLE) |=> !mem_req_r
  ) else $error("fetch started while halted");

  chk_tx_offer_held: assert property (
    (tx_valid_r && !tx_ready) |=> tx_valid_r && $stable(txd_r)
  ) else $error("buffer offer changed before it was taken");

endmodule : etd_tx_fetch

/* File: include/etd_pkg.sv */
package etd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BASE = 8'h04;
  localparam logic [7:0] OFS_CUR  = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // Control register fields
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_IPG  = 1;
  localparam int CTRL_TCPG = 2;
  localparam int CTRL_UDPG = 3;

  // Status and mask fields
  localparam int ST_DONE = 0;
  localparam int ST_HALT = 1;
  localparam int ST_HOLD = 4;

  // Descriptor fields
  localparam int W0_OWN     = 31;
  localparam int W1_IC      = 31;
  localparam int W1_FS      = 30;
  localparam int W1_LS      = 29;
  localparam int W1_IP      = 28;
  localparam int W1_TCP     = 27;
  localparam int W1_UDP     = 26;
  localparam int W1_WRAP    = 25;
  localparam int W1_LEN_HI  = 13;
  localparam int LAST_WORD  = 3;

  // Reset values and constants
  localparam logic [3:0]  RST_CTRL     = 4'h0;
  localparam logic [1:0]  RST_STAT     = 2'h0;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [31:0] DESC_W0_DONE = 32'h0000_0000;
  localparam logic [31:0] WORD_STEP    = 32'h0000_0004;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FETCH = 3'b001,
    S_ISSUE = 3'b010,
    S_XFER  = 3'b011,
    S_DONE  = 3'b100,
    S_WB    = 3'b101,
    S_NEXT  = 3'b110
  } etd_state_type;

  typedef struct packed {
    logic [31:0] buf_addr;
    logic [13:0] len;
    logic        first;
    logic        last;
    logic        ins_ip;
    logic        ins_tcp;
    logic        ins_udp;
  } etd_txd_type;

endpackage : etd_pkg

/* File: tb/etd_host_model.sv */
`timescale 1ns/1ps
module etd_host_model
  import etd_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Answer delay
  input  wire logic [3:0]  lat,
  // Descriptor memory
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  // MAC side
  input  wire etd_txd_type tx_desc,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic             tx_done
);
  logic [31:0] mem [0:63];
  etd_txd_type seen [0:7];
  logic [2:0]  acc_cnt;
  logic [3:0]  wait_cnt;
  logic [3:0]  done_cnt;
  logic        busy;
  wire         serve = mem_req && !mem_ack && wait_cnt >= lat;

  // Data line scrambles every cycle when not answering
  always @(posedge clock) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h5a5a_a5a5;
      wait_cnt <= 4'h0;
    end else begin
      mem_ack <= serve;
      mem_rdata <= ~mem_rdata;
      wait_cnt <= (mem_req && !serve && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
      if (serve && mem_we) mem[mem_addr[7:2]] <= mem_wdata;
      if (serve && !mem_we) mem_rdata <= mem[mem_addr[7:2]];
    end
  end

  // Takes one descriptor, then reports it sent after lat + 1 cycles
  always @(posedge clock) begin
    if (!rst_b) begin
      tx_ready <= 1'b0;
      tx_done <= 1'b0;
      busy <= 1'b0;
      acc_cnt <= 3'h0;
      done_cnt <= 4'h0;
    end else begin
      tx_done <= 1'b0;
      if (tx_valid && tx_ready) begin
        tx_ready <= 1'b0;
        busy <= 1'b1;
        done_cnt <= lat;
        seen[acc_cnt] <= tx_desc;
        acc_cnt <= acc_cnt + 3'h1;
      end else if (busy) begin
        tx_done <= done_cnt == 4'h0;
        busy <= done_cnt != 4'h0;
        done_cnt <= done_cnt - 4'h1;
      end else begin
        tx_ready <= tx_valid;
      end
    end
  end
endmodule : etd_host_model

/* File: tb/etd_tx_fetch_tb.sv */
`timescale 1ns/1ps
module etd_tx_fetch_tb
  import etd_pkg::*;
;
  logic        clock, rst_b, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        mem_req, mem_we, mem_ack, tx_valid, tx_ready, tx_done, irq;
  logic [31:0] mem_addr, mem_wdata, mem_rdata;
  logic [3:0]  lat;
  etd_txd_type tx_desc;
  int          errors, num_checks;
  logic [7:0]  offs [6] = '{OFS_CTRL, OFS_BASE, OFS_CUR, OFS_STAT, OFS_MASK, 8'h20};

  etd_tx_fetch i_etd_tx_fetch (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .tx_desc(tx_desc),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_done(tx_done), .irq(irq));
  etd_host_model i_host (.clock(clock), .rst_b(rst_b), .lat(lat), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .tx_desc(tx_desc), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_done(tx_done));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic complete_run;
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rv = hrdata;
  endtask : bus

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(what, {32'h0, rv}, {32'h0, exp});
  endtask : rdchk

  task automatic setd(input int i, input logic [31:0] w1, input logic [31:0] w2, input logic [31:0] w3);
    i_host.mem[i + 1] = w1;
    i_host.mem[i + 2] = w2;
    i_host.mem[i + 3] = w3;
    i_host.mem[i] = 32'h8000_0000;
  endtask : setd

  task automatic wait_halt;
    rv = 32'h0000_0000;
    for (int i = 0; i < 200 && rv[ST_HALT] !== 1'b1; i++) bus(1'b0, OFS_STAT, 32'h0000_0000);
    check("halt reached", {63'h0, rv[ST_HALT]}, 64'h1);
  endtask : wait_halt

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clock);
    check("irq", {63'h0, irq}, {63'h0, exp});
  endtask : irq_chk

  initial begin
    errors = 0;
    num_checks = 0;
    {rst_b, hsel, hwrite, htrans, haddr, hwdata, lat} = '0;
    hsize = 3'b010;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    foreach (offs[i]) rdchk("reset value", offs[i], 32'h0000_0000);
    bus(1'b1, 8'h20, 32'hffff_ffff);
    bus(1'b1, OFS_CUR, 32'h0000_00f0);
    rdchk("unmapped", 8'h20, 32'h0000_0000);
    rdchk("cur read only", OFS_CUR, 32'h0000_0000);
    // First descriptor of the ring handed over last
    setd(20, 32'h6000_0000, 32'h0000_2000, 32'h0000_0060);
    setd(24, 32'h6600_0008, 32'h0000_3000, 32'h0000_0080);
    setd(16, 32'he800_0040, 32'h0000_1000, 32'h0000_0050);
    bus(1'b1, OFS_BASE, 32'h0000_0040);
    bus(1'b1, OFS_CTRL, 32'h0000_0007);
    wait_halt();
    check("handoffs", {61'h0, i_host.acc_cnt}, 64'h2);
    check("desc a", {13'h0, i_host.seen[0]}, {13'h0, 32'h0000_1000, 14'h0040, 5'h1e});
    check("desc c", {13'h0, i_host.seen[1]}, {13'h0, 32'h0000_3000, 14'h0008, 5'h1f});
    for (int i = 16; i < 28; i += 4) check("own", {32'h0, i_host.mem[i]}, 64'h0);
    rdchk("cur wrap", OFS_CUR, 32'h0000_0040);
    rdchk("stat", OFS_STAT, 32'h0000_0013);
    check("hresp", {63'h0, hresp}, 64'h0);
    irq_chk(1'b0);
    bus(1'b1, OFS_MASK, 32'h0000_0001);
    irq_chk(1'b1);
    bus(1'b1, OFS_STAT, 32'h0000_0001);
    irq_chk(1'b0);
    lat <= 4'h3;
    setd(16, 32'hd800_0004, 32'h0000_1000, 32'h0000_0050);
    bus(1'b1, OFS_CTRL, 32'h0000_0009);
    bus(1'b1, OFS_STAT, 32'h0000_0002);
    wait_halt();
    check("desc a2", {13'h0, i_host.seen[2]}, {13'h0, 32'h0000_1000, 14'h0004, 5'h17});
    rdchk("stat no ls", OFS_STAT, 32'h0000_0012);
    rdchk("cur next", OFS_CUR, 32'h0000_0050);
    irq_chk(1'b0);
    bus(1'b1, OFS_MASK, 32'h0000_0003);
    irq_chk(1'b1);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    complete_run();
  end
endmodule : etd_tx_fetch_tb
